// file: core/fcr_pkg.sv
// fcr_pkg: offsets, field positions, reset values and codes of the front end control registers
// assumes a 16-bit register word reached through a simple internal register port
package fcr_pkg;
    localparam logic [7:0]  ADDR_REG_OFS      = 8'h09;
    localparam logic [7:0]  PIN_CFG_OFS       = 8'h0b;
    localparam logic [7:0]  UNLOCK_OFS        = 8'h0d;
    localparam logic [7:0]  SRST_OFS          = 8'h0f;
    localparam logic [7:0]  MODE_OFS          = 8'h10;
    localparam logic [7:0]  QCFG_OFS          = 8'h11;

    localparam logic [15:0] UNLOCK_RST        = 16'h0000;
    localparam logic [15:0] UNLOCK_ALWAYS     = 16'h04ad;
    localparam logic [15:0] UNLOCK_PIN0       = 16'h44ad;
    localparam logic [15:0] UNLOCK_PIN1       = 16'h84ad;
    localparam logic [15:0] UNLOCK_BOTH       = 16'hc4ad;
    localparam logic [7:0]  ADDR_KEY          = 8'had;
    localparam logic [6:0]  BUS_ADDR_RST      = 7'h64;

    localparam logic [4:0]  PIN0_CFG_RST      = 5'h00;
    localparam logic [4:0]  PIN0_LOW          = 5'h10;
    localparam logic [4:0]  PIN0_HIGH         = 5'h11;
    localparam logic [4:0]  PIN0_OSC          = 5'h13;

    localparam int          READBACK_BIT      = 13;
    localparam int          OVERRUN_BIT       = 12;
    localparam int          SLOTB_FMT_LSB     = 6;
    localparam logic [15:0] QCFG_RST          = 16'h1000;
    localparam logic [15:0] QCFG_WMASK        = 16'h31ff;

    localparam int          SRST_CYCLES       = 4;

    typedef enum logic [1:0] {
        FCR_STANDBY = 2'h0,
        FCR_PROGRAM = 2'h1,
        FCR_NORMAL  = 2'h2
    } fcr_mode_t;

    typedef enum logic [2:0] {
        FCR_FMT_NONE  = 3'h0,
        FCR_FMT_SUM16 = 3'h1,
        FCR_FMT_SUM32 = 3'h2,
        FCR_FMT_CH16  = 3'h4,
        FCR_FMT_CH32  = 3'h6
    } fcr_fmt_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } fcr_req_t;

    typedef struct packed {
        logic        readback_average;
        logic        overrun_guard;
        logic [2:0]  slotb_format;
        logic        slotb_format_valid;
    } fcr_qcfg_t;

    typedef enum logic [1:0] {
        FCR_RUN   = 2'b01,
        FCR_RESET = 2'b10
    } fcr_state_t;
endpackage

// file: core/fcr_regs.sv
// fcr_regs: register bank for pin 0 select, address unlock, soft reset, mode and queue config
// assumes the serial interface decodes frames into one-cycle rd/wr strobes on req,
// and acknowledges each write made outside a soft reset with wr_ack before any soft reset takes effect
// Behaviour
// - pin0 codes 10,11,13 give low,high,oscillator
// - unlock 04AD always permits address change
// - 44AD needs pin0 high, 84AD pin1
// - C4AD needs both pins high
// - soft reset bit resets, clears when done
// - write acknowledged first, then standby defaults
// - mode 0 standby, 1 program, 2 normal
// - bit13 picks sum or average readback
// - bit12 default one, stop when queue full
// - slot B format codes 0,1,2,4 decoded
// - slot B format 6 is 32-bit channels
`timescale 1ns/1ps
`default_nettype none
module fcr_regs
    import fcr_pkg::*;
#(
    parameter int RST_LEN = SRST_CYCLES
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire fcr_pkg::fcr_req_t req,
    input  wire logic             general_pin_zero,
    input  wire logic             general_pin_one,
    input  wire logic             osc_32k,
    output logic [15:0]           rdata,
    output logic                  rvalid,
    output logic                  wr_ack,
    output logic                  pin0_drive,
    output logic                  pin0_override,
    output logic [6:0]            bus_address,
    output fcr_pkg::fcr_mode_t    operating_mode,
    output fcr_pkg::fcr_qcfg_t    queue_config,
    output logic                  soft_reset_busy
);
    import fcr_pkg::*;

    // stored register fields
    logic [15:0] unlock_r;
    logic [6:0]  addr_r;
    logic [4:0]  pin0_alternate_select_r;
    logic [7:0]  pin1_cfg_r;
    logic        soft_reset_bit_r;
    fcr_mode_t   mode_r;
    logic [15:0] qcfg_r;
    fcr_qcfg_t   qcfg_out_r;

    // next values of the stored fields
    logic [15:0] unlock_nxt;
    logic [6:0]  addr_nxt;
    logic [4:0]  pin0_alternate_select_nxt;
    logic [7:0]  pin1_cfg_nxt;
    logic        soft_reset_bit_nxt;
    fcr_mode_t   mode_nxt;
    logic [15:0] qcfg_nxt;

    // soft reset sequencer
    fcr_state_t  state_r;
    fcr_state_t  state_nxt;
    logic [7:0]  cnt_r;
    logic [7:0]  cnt_nxt;

    // answer and pin flops
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic        rvalid_r;
    logic        rvalid_nxt;
    logic        ack_r;
    logic        ack_nxt;
    logic        drive_r;
    logic        drive_nxt;
    logic        ovr_r;
    logic        ovr_nxt;

    // write strobe aimed at one offset
    function automatic logic hit(input fcr_req_t r, input logic [7:0] ofs);
        return r.wr && (r.addr == ofs);
    endfunction

    // pin 0 codes that replace the pin's normal function
    function automatic logic pin0_fixed(input logic [4:0] code);
        return (code == PIN0_LOW) || (code == PIN0_HIGH) || (code == PIN0_OSC);
    endfunction

    // listed slot B formats; reserved codes must not reach the queue writer
    function automatic logic fmt_known(input logic [2:0] code);
        return (code == FCR_FMT_NONE) || (code == FCR_FMT_SUM16) ||
               (code == FCR_FMT_SUM32) || (code == FCR_FMT_CH16) ||
               (code == FCR_FMT_CH32);
    endfunction

    // fields of the queue word as the data path consumes them
    function automatic fcr_qcfg_t qcfg_fields(input logic [15:0] word);
        fcr_qcfg_t f;
        f.readback_average   = word[READBACK_BIT];
        f.overrun_guard      = word[OVERRUN_BIT];
        f.slotb_format       = word[SLOTB_FMT_LSB +: 3];
        f.slotb_format_valid = fmt_known(word[SLOTB_FMT_LSB +: 3]);
        return f;
    endfunction

    // request decode; nothing is taken while the soft reset runs
    wire logic soft_rst   = (state_r == FCR_RESET);
    wire logic regs_clear = rst || soft_rst;
    wire logic cnt_done   = (cnt_r == 8'(RST_LEN - 1));
    wire logic wr_take    = req.wr && !soft_rst;
    wire logic rd_take    = req.rd && !soft_rst;
    wire logic wr_unlock  = hit(req, UNLOCK_OFS);
    wire logic wr_addr    = hit(req, ADDR_REG_OFS);
    wire logic wr_pin     = hit(req, PIN_CFG_OFS);
    wire logic wr_srst    = hit(req, SRST_OFS);
    wire logic wr_mode    = hit(req, MODE_OFS);
    wire logic wr_qcfg    = hit(req, QCFG_OFS);
    wire logic srst_req   = wr_srst && req.wdata[0] && !soft_rst;

    // unlock qualifier chosen by the stored key
    wire logic unlock_ok =
        (unlock_r == UNLOCK_ALWAYS) ||
        ((unlock_r == UNLOCK_PIN0) && general_pin_zero) ||
        ((unlock_r == UNLOCK_PIN1) && general_pin_one) ||
        ((unlock_r == UNLOCK_BOTH) && general_pin_zero && general_pin_one);
    // a write without the key in the upper byte leaves the address alone
    wire logic addr_wr = wr_addr && unlock_ok
                         && (req.wdata[15:8] == ADDR_KEY);

    wire logic [1:0] mode_w = req.wdata[1:0];
    // only defined modes are accepted; others keep the current mode
    wire logic mode_ok = (mode_w == FCR_STANDBY) || (mode_w == FCR_PROGRAM)
                         || (mode_w == FCR_NORMAL);

    wire logic pin0_high_sel = (pin0_alternate_select_r == PIN0_HIGH);
    wire logic pin0_osc_sel  = (pin0_alternate_select_r == PIN0_OSC);

    // read words; reserved bits read back as zero
    wire logic [15:0] addr_word = {8'h00, addr_r, 1'b0};
    wire logic [15:0] pin_word  = {3'h0, pin1_cfg_r[4:0], 3'h0, pin0_alternate_select_r};
    wire logic [15:0] srst_word = {15'h0000, soft_reset_bit_r};
    wire logic [15:0] mode_word = {14'h0000, mode_r};
    wire logic [15:0] rd_mux =
        (req.addr == ADDR_REG_OFS) ? addr_word :
        (req.addr == PIN_CFG_OFS)  ? pin_word :
        (req.addr == UNLOCK_OFS)   ? unlock_r :
        (req.addr == SRST_OFS)     ? srst_word :
        (req.addr == MODE_OFS)     ? mode_word :
        (req.addr == QCFG_OFS)     ? qcfg_r : 16'h0000;

    // next values; both resets are applied in the flops below
    assign unlock_nxt = wr_unlock ? req.wdata : unlock_r;
    assign addr_nxt   = addr_wr ? req.wdata[7:1] : addr_r;
    assign pin0_alternate_select_nxt = wr_pin ? req.wdata[4:0] : pin0_alternate_select_r;
    assign pin1_cfg_nxt = wr_pin ? {3'h0, req.wdata[12:8]} : pin1_cfg_r;
    assign mode_nxt   = (wr_mode && mode_ok) ? fcr_mode_t'(mode_w) : mode_r;
    assign qcfg_nxt   = wr_qcfg ? (req.wdata & QCFG_WMASK) : qcfg_r;

    // the bit stays set through the reset window and clears at its end
    assign soft_reset_bit_nxt = srst_req ? 1'b1 :
                                (soft_rst && cnt_done) ? 1'b0 : soft_reset_bit_r;

    always_comb begin
        case (state_r)
            FCR_RUN:   state_nxt = srst_req ? FCR_RESET : FCR_RUN;
            FCR_RESET: state_nxt = cnt_done ? FCR_RUN : FCR_RESET;
            default:   state_nxt = FCR_RUN;
        endcase
    end

    // counter runs only inside the window, so every soft reset lasts RST_LEN cycles
    assign cnt_nxt = soft_rst ? cnt_r + 8'h01 : 8'h00;

    // the reset write is answered one cycle after its strobe, before the registers are cleared
    assign ack_nxt    = wr_take;
    assign rvalid_nxt = rd_take;
    assign rdata_nxt  = rd_take ? rd_mux : rdata_r;

    // pin 0 override follows the stored code one cycle later
    assign ovr_nxt   = pin0_fixed(pin0_alternate_select_r);
    assign drive_nxt = pin0_high_sel || (pin0_osc_sel && osc_32k);

    // one flop per field; soft reset clears every stored field and pin flop here, but not
    // the soft reset bit, the sequencer or the answer flops, which see only power-on reset
    always_ff @(posedge ref_clk) begin
        if (regs_clear)
            unlock_r <= UNLOCK_RST;
        else
            unlock_r <= unlock_nxt;
    end

    always_ff @(posedge ref_clk) begin
        if (regs_clear)
            addr_r <= BUS_ADDR_RST;
        else
            addr_r <= addr_nxt;
    end

    always_ff @(posedge ref_clk) begin
        if (regs_clear)
            pin0_alternate_select_r <= PIN0_CFG_RST;
        else
            pin0_alternate_select_r <= pin0_alternate_select_nxt;
    end

    always_ff @(posedge ref_clk) begin
        if (regs_clear)
            pin1_cfg_r <= 8'h00;
        else
            pin1_cfg_r <= pin1_cfg_nxt;
    end

    always_ff @(posedge ref_clk) begin
        if (regs_clear)
            mode_r <= FCR_STANDBY;
        else
            mode_r <= mode_nxt;
    end

    always_ff @(posedge ref_clk) begin
        if (regs_clear)
            qcfg_r <= QCFG_RST;
        else
            qcfg_r <= qcfg_nxt;
    end

    // decoded fields are registered from the next word so they change with it
    always_ff @(posedge ref_clk) begin
        if (regs_clear)
            qcfg_out_r <= qcfg_fields(QCFG_RST);
        else
            qcfg_out_r <= qcfg_fields(qcfg_nxt);
    end

    always_ff @(posedge ref_clk) begin
        if (regs_clear)
            drive_r <= 1'b0;
        else
            drive_r <= drive_nxt;
    end

    always_ff @(posedge ref_clk) begin
        if (regs_clear)
            ovr_r <= 1'b0;
        else
            ovr_r <= ovr_nxt;
    end

    // sequencer and answer flops see only the power-on reset
    always_ff @(posedge ref_clk) begin
        if (rst)
            state_r <= FCR_RUN;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge ref_clk) begin
        if (rst)
            cnt_r <= 8'h00;
        else
            cnt_r <= cnt_nxt;
    end

    always_ff @(posedge ref_clk) begin
        if (rst)
            soft_reset_bit_r <= 1'b0;
        else
            soft_reset_bit_r <= soft_reset_bit_nxt;
    end

    always_ff @(posedge ref_clk) begin
        if (rst)
            ack_r <= 1'b0;
        else
            ack_r <= ack_nxt;
    end

    always_ff @(posedge ref_clk) begin
        if (rst)
            rvalid_r <= 1'b0;
        else
            rvalid_r <= rvalid_nxt;
    end

    always_ff @(posedge ref_clk) begin
        if (rst)
            rdata_r <= 16'h0000;
        else
            rdata_r <= rdata_nxt;
    end

    // every output comes straight from a flop
    assign rdata           = rdata_r;
    assign rvalid          = rvalid_r;
    assign wr_ack          = ack_r;
    assign pin0_drive      = drive_r;
    assign pin0_override   = ovr_r;
    assign bus_address     = addr_r;
    assign operating_mode  = mode_r;
    assign queue_config    = qcfg_out_r;
    assign soft_reset_busy = soft_reset_bit_r;
endmodule // fcr_regs
`default_nettype wire

// file: testbench/fcr_host.sv
// fcr_host: host model issuing one-cycle register strobes
// assumes the bank answers one cycle after each strobe
`timescale 1ns/1ps
`default_nettype none
module fcr_host
    import fcr_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         rvalid,
    input  wire logic         wr_ack,
    input  wire logic [15:0]  rdata,
    output fcr_pkg::fcr_req_t req
);
    initial req = '{1'b0, 1'b0, 8'h00, 16'h0000};
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                        output logic ok, output logic [15:0] q);
        @(negedge ref_clk);
        req = '{w, !w, a, d};
        @(negedge ref_clk);
        ok = w ? wr_ack : rvalid;
        q = rdata;
        // idle bus shows inverted values so stale data never looks live
        req = '{1'b0, 1'b0, ~a, ~d};
    endtask
endmodule // fcr_host
`default_nettype wire

// file: testbench/fcr_regs_chk.sv
// fcr_regs_chk: port-level assertions for the register bank
// assumes fcr_regs with its default soft reset length
`timescale 1ns/1ps
`default_nettype none
module fcr_regs_chk
    import fcr_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              rst,
    input wire fcr_pkg::fcr_req_t req,
    input wire logic              rvalid,
    input wire logic              wr_ack,
    input wire logic [6:0]        bus_address,
    input wire fcr_pkg::fcr_mode_t operating_mode,
    input wire fcr_pkg::fcr_qcfg_t queue_config,
    input wire logic              soft_reset_busy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire srst_wr = req.wr && req.addr == SRST_OFS && req.wdata[0] && !soft_reset_busy;
    sequence s_srst_start; srst_wr ##1 (wr_ack && soft_reset_busy); endsequence
    sequence s_srst_done; !soft_reset_busy && operating_mode == FCR_STANDBY; endsequence
    a_write_acked: assert property (req.wr && !soft_reset_busy |=> wr_ack)
        else $error("write not acknowledged");
    a_read_answered: assert property (req.rd && !soft_reset_busy |=> rvalid)
        else $error("read not answered");
    a_mode_legal: assert property (operating_mode != 2'h3)
        else $error("illegal mode code");
    a_reset_defaults: assert property ($fell(rst) |-> bus_address == BUS_ADDR_RST
        && queue_config.overrun_guard && operating_mode == FCR_STANDBY) else $error("bad defaults");
    a_srst_flow: assert property (srst_wr |-> s_srst_start ##[1:6] s_srst_done)
        else $error("soft reset sequence wrong");
    a_busy_silent: assert property (soft_reset_busy && $past(soft_reset_busy) |-> !wr_ack && !rvalid)
        else $error("answer during soft reset");
    a_busy_bounded: assert property (soft_reset_busy |-> ##[1:6] !soft_reset_busy)
        else $error("soft reset bit stuck");
    a_fmt_valid: assert property (queue_config.slotb_format_valid ==
        (queue_config.slotb_format inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h6})) else $error("bad format flag");
    a_addr_cause: assert property ($changed(bus_address) && !soft_reset_busy |-> $past(req.wr)
        && $past(req.addr) == ADDR_REG_OFS && $past(req.wdata[15:8]) == ADDR_KEY) else $error("bad addr change");
endmodule // fcr_regs_chk
bind fcr_regs fcr_regs_chk fcr_regs_chk_inst (.ref_clk(ref_clk), .rst(rst), .req(req), .rvalid(rvalid),
    .wr_ack(wr_ack), .bus_address(bus_address), .operating_mode(operating_mode),
    .queue_config(queue_config), .soft_reset_busy(soft_reset_busy));
`default_nettype wire

// file: testbench/tb_frontend_control_registers.sv
// tb_frontend_control_registers: directed register tests through the host model
// assumes the checker is bound to fcr_regs
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_frontend_control_registers;
    import fcr_pkg::*;
    logic        ref_clk, rst, pin_zero, pin_one, osc, rvalid, wr_ack, drv, ovr, busy, ok;
    logic [15:0] rdata, q;
    logic [6:0]  bus_address, exp_addr;
    fcr_req_t    req;
    fcr_mode_t   mode;
    fcr_qcfg_t   qcfg;
    int          mismatches = 0, tests_run = 0;
    logic [2:0]  fmts[5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6};
    logic [4:0]  pcodes[3] = '{PIN0_LOW, PIN0_HIGH, PIN0_OSC};
    logic [15:0] keys[7] = '{16'h04ad, 16'h44ad, 16'h44ad, 16'h84ad, 16'h84ad, 16'hc4ad, 16'hc4ad};
    logic [1:0]  pins[7] = '{2'h0, 2'h2, 2'h1, 2'h1, 2'h2, 2'h1, 2'h3};
    fcr_regs fcr_regs_inst (.ref_clk(ref_clk), .rst(rst), .req(req), .general_pin_zero(pin_zero),
        .general_pin_one(pin_one), .osc_32k(osc), .rdata(rdata), .rvalid(rvalid), .wr_ack(wr_ack),
        .pin0_drive(drv), .pin0_override(ovr), .bus_address(bus_address),
        .operating_mode(mode), .queue_config(qcfg), .soft_reset_busy(busy));
    fcr_host fcr_host_inst (.ref_clk(ref_clk), .rvalid(rvalid), .wr_ack(wr_ack), .rdata(rdata),
        .req(req));
    task automatic w(input logic [7:0] a, input logic [15:0] d);
        fcr_host_inst.xfer(1'b1, a, d, ok, q);
        `CHK("wr_ack", 1'b1, ok)
    endtask
    task automatic r(input logic [7:0] a, input logic [15:0] e);
        fcr_host_inst.xfer(1'b0, a, 16'h0000, ok, q);
        `CHK("rvalid", 1'b1, ok)
        `CHK("rdata", e, q)
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #100us;
        mismatches++;
        give_verdict();
    end
    initial begin
        rst = 1'b1; pin_zero = 1'b0; pin_one = 1'b0; osc = 1'b1;
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        r(QCFG_OFS, QCFG_RST);
        r(MODE_OFS, 16'h0000);
        r(UNLOCK_OFS, UNLOCK_RST);
        r(8'h20, 16'h0000);
        `CHK("override", 1'b0, ovr)
        for (int m = 0; m < 4; m++) begin
            w(MODE_OFS, 16'(m));
            `CHK("mode", (m == 3) ? 2'h2 : 2'(m), mode)
        end
        w(QCFG_OFS, 16'hffff);
        r(QCFG_OFS, QCFG_WMASK);
        `CHK("average", 1'b1, qcfg.readback_average)
        `CHK("fmt_valid", 1'b0, qcfg.slotb_format_valid)
        w(QCFG_OFS, 16'h0000);
        `CHK("guard", 1'b0, qcfg.overrun_guard)
        `CHK("average", 1'b0, qcfg.readback_average)
        foreach (fmts[i]) begin
            w(QCFG_OFS, 16'h1000 | {7'h00, fmts[i], 6'h00});
            `CHK("fmt", fmts[i], qcfg.slotb_format)
            `CHK("fmt_valid", 1'b1, qcfg.slotb_format_valid)
        end
        foreach (pcodes[i]) begin
            w(PIN_CFG_OFS, {11'h000, pcodes[i]});
            repeat (2) @(negedge ref_clk);
            `CHK("override", 1'b1, ovr)
            `CHK("drive", pcodes[i] != PIN0_LOW, drv)
        end
        osc = 1'b0;
        repeat (3) @(negedge ref_clk);
        `CHK("drive", 1'b0, drv)
        w(ADDR_REG_OFS, 16'had22);
        exp_addr = BUS_ADDR_RST;
        `CHK("bus_address", exp_addr, bus_address)
        foreach (keys[i]) begin
            {pin_one, pin_zero} = pins[i];
            w(UNLOCK_OFS, keys[i]);
            w(ADDR_REG_OFS, {ADDR_KEY, 7'(8'h30 + i), 1'b0});
            if (i % 2 == 0) exp_addr = 7'(8'h30 + i);
            `CHK("bus_address", exp_addr, bus_address)
        end
        // key byte missing: the change must be refused even though unlocked
        w(ADDR_REG_OFS, 16'h0022);
        `CHK("bus_address", exp_addr, bus_address)
        w(MODE_OFS, 16'h0002);
        w(SRST_OFS, 16'h0001);
        for (int n = 0; n < 20 && busy !== 1'b0; n++) @(negedge ref_clk);
        `CHK("busy", 1'b0, busy)
        `CHK("mode", FCR_STANDBY, mode)
        `CHK("bus_address", BUS_ADDR_RST, bus_address)
        r(SRST_OFS, 16'h0000);
        r(QCFG_OFS, QCFG_RST);
        give_verdict();
    end
endmodule // tb_frontend_control_registers
`default_nettype wire
